// ===== hw/bisig_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "bisig_params.svh"

module bisig_seq import bisig_pkg::*; #(
  parameter int unsigned INIT_MAX_CYC = `BISIG_INIT_MAX_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic bootDone,
  input wire logic initDone,
  input wire logic batchExtend,
  output logic attnOut,
  output logic attnOeN,
  output logic initFinished,
  output logic initOverdue,
  output bisig_state_t seqState
);

  logic bootSync;
  logic initSync;
  logic extSync;
  bisig_state_t state_reg;
  bisig_state_t state_next;
  bisig_pin_t pin_reg;
  bisig_pin_t pin_next;
  logic fin_reg;
  logic fin_next;
  logic over_reg;
  logic over_next;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;

  // Status inputs come from firmware domains; pass them through synchronisers
  bisig_sync uBootSync (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn),
    .asyncIn(bootDone), .syncOut(bootSync)
  );
  bisig_sync uInitSync (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn),
    .asyncIn(initDone), .syncOut(initSync)
  );
  bisig_sync uExtSync (
    .mclk(mclk), .resetn(resetn), .clkEn(clkEn),
    .asyncIn(batchExtend), .syncOut(extSync)
  );

  // Next state and pin drive
  always_comb begin
    state_next = state_reg;
    pin_next = pin_reg;
    fin_next = fin_reg;
    case (state_reg)
      BISIG_RESET: begin
        state_next = BISIG_BOOTING;
      end
      BISIG_BOOTING: begin
        if (bootSync) begin
          state_next = BISIG_INITIALIZING;
        end
      end
      BISIG_INITIALIZING: begin
        if (initSync || (over_reg && !extSync)) begin
          state_next = BISIG_FINISHED;
        end
      end
      BISIG_FINISHED: begin
        state_next = BISIG_FINISHED;
      end
      default: begin
        state_next = BISIG_RESET;
      end
    endcase
    // Drive follows the next state so the pin is registered
    case (state_next)
      BISIG_INITIALIZING: begin
        pin_next = '{level: `BISIG_LINE_BUSY, oeN: 1'b0};
      end
      BISIG_FINISHED: begin
        pin_next = '{level: `BISIG_LINE_DONE, oeN: 1'b0};
        fin_next = 1'b1;
      end
      default: begin
        pin_next = '{level: 1'b1, oeN: 1'b1};
      end
    endcase
  end

  // Deadline timer from reset release
  always_comb begin
    tmr_next = tmr_reg;
    over_next = over_reg;
    if (!fin_reg && !over_reg) begin
      if (tmr_reg >= INIT_MAX_CYC - 32'h2) begin
        over_next = 1'b1;
      end else begin
        tmr_next = tmr_reg + 32'h1;
      end
    end
  end

  // Registers; reset releases the line
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= BISIG_RESET;
      pin_reg <= '{level: 1'b1, oeN: 1'b1};
      fin_reg <= 1'b0;
      over_reg <= 1'b0;
      tmr_reg <= 32'h0;
    end else if (clkEn) begin
      state_reg <= state_next;
      pin_reg <= pin_next;
      fin_reg <= fin_next;
      over_reg <= over_next;
      tmr_reg <= tmr_next;
    end
  end

  assign attnOut = pin_reg.level;
  assign attnOeN = pin_reg.oeN;
  assign initFinished = fin_reg;
  assign initOverdue = over_reg;
  assign seqState = state_reg;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  chk_boot_released: assert property (
    (state_reg == BISIG_BOOTING) |-> attnOeN)
    else $error("Line driven while booting");
  chk_init_high: assert property (
    (state_reg == BISIG_INITIALIZING) |-> (!attnOeN && attnOut))
    else $error("Line not driven high while initializing");
  chk_done_low: assert property (
    (state_reg == BISIG_FINISHED) |-> (!attnOeN && !attnOut))
    else $error("Line not driven low when finished");
  chk_finish_sticky: assert property (
    initFinished |=> initFinished)
    else $error("Finished flag dropped");
  chk_fall_finish: assert property (
    (clkEn && $fell(attnOut) && !attnOeN) |-> initFinished)
    else $error("Falling edge without finished state");
  chk_deadline_hit: assert property (
    (clkEn && over_reg && !extSync && state_reg == BISIG_INITIALIZING)
      |=> (state_reg == BISIG_FINISHED))
    else $error("Deadline passed without release");
  chk_boot_step: assert property (
    (clkEn && state_reg == BISIG_BOOTING && bootSync)
      |=> (state_reg == BISIG_INITIALIZING))
    else $error("Boot completion ignored");
  chk_reset_leave: assert property (
    (clkEn && state_reg == BISIG_RESET) |=> (state_reg == BISIG_BOOTING))
    else $error("Reset state not left");

  cov_boot: cover property (state_reg == BISIG_INITIALIZING);
  cov_done: cover property (state_reg == BISIG_FINISHED && !initOverdue);
  cov_overdue: cover property (state_reg == BISIG_FINISHED && initOverdue);

endmodule : bisig_seq

`default_nettype wire

// ===== shared/bisig_params.svh
`ifndef BISIG_PARAMS_SVH
`define BISIG_PARAMS_SVH

// System clock rate in kHz (20 MHz, 50 ns period)
`define BISIG_CLK_KHZ 20000
// Longest time from reset release to the attention line going low, in ms
`define BISIG_INIT_MAX_MS 500
// Longest time in cycles, rounded down
`define BISIG_INIT_MAX_CYC (`BISIG_INIT_MAX_MS * `BISIG_CLK_KHZ)
// Least reset pulse the far end must give, in ns
`define BISIG_RESET_MIN_NS 1250
// Attention line drive level while initialization runs
`define BISIG_LINE_BUSY 1'b1
// Attention line drive level once initialization is done
`define BISIG_LINE_DONE 1'b0

`endif

// ===== shared/bisig_pkg.sv
package bisig_pkg;

  // Sequencing states of the attention line
  typedef enum logic [1:0] {
    BISIG_RESET,
    BISIG_BOOTING,
    BISIG_INITIALIZING,
    BISIG_FINISHED
  } bisig_state_t;

  // Attention line pin drive: level and active-low output enable
  typedef struct packed {
    logic level;
    logic oeN;
  } bisig_pin_t;

endpackage : bisig_pkg

// ===== hw/bisig_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bisig_sync (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic asyncIn,
  output logic syncOut
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic out_reg;
  logic out_next;

  // Shift the input; accept a change once stages two and three agree
  always_comb begin
    stage_next = {stage_reg[1:0], asyncIn};
    out_next = out_reg;
    if (stage_reg[1] == stage_reg[2]) begin
      out_next = stage_reg[2];
    end
  end

  // Registers, frozen while the clock enable is low
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stage_reg <= 3'h0;
      out_reg <= 1'b0;
    end else if (clkEn) begin
      stage_reg <= stage_next;
      out_reg <= out_next;
    end
  end

  assign syncOut = out_reg;

endmodule : bisig_sync

`default_nettype wire

// ===== verif/bisig_host.sv
`timescale 1ns/1ps
`default_nettype none

module bisig_host (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic attnOut,
  input wire logic attnOeN,
  output logic attnLine,
  output logic cfgAllowed
);
  // Pull-up wins while the device lets go of the line
  assign attnLine = attnOeN ? 1'b1 : attnOut;
  // Config traffic may start only after the line falls
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfgAllowed <= 1'b0;
    end else if (!attnLine) begin
      cfgAllowed <= 1'b1;
    end
  end
endmodule : bisig_host

`default_nettype wire

// ===== verif/tb_boot_init_status_signal.sv
`timescale 1ns/1ps
`default_nettype none

module tb_boot_init_status_signal import bisig_pkg::*;;
  logic mclk, resetn, clkEn, bootDone, initDone, batchExtend;
  logic attnOut, attnOeN, initFinished, initOverdue, attnLine, cfgAllowed;
  bisig_state_t seqState;
  int failures = 0;
  int num_checks = 0;

  bisig_seq #(.INIT_MAX_CYC(40)) dut (.mclk(mclk), .resetn(resetn),
    .clkEn(clkEn), .bootDone(bootDone), .initDone(initDone),
    .batchExtend(batchExtend), .attnOut(attnOut), .attnOeN(attnOeN),
    .initFinished(initFinished), .initOverdue(initOverdue),
    .seqState(seqState));
  bisig_host host (.mclk(mclk), .resetn(resetn), .attnOut(attnOut),
    .attnOeN(attnOeN), .attnLine(attnLine), .cfgAllowed(cfgAllowed));

  // Clock and quiet inputs
  initial begin
    {resetn, clkEn, bootDone, initDone, batchExtend} = 5'h08;
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [3:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Bounded wait for a level, then judge it
  task automatic wait_for(input string what, ref logic sig,
                          input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(what, {3'h0, sig}, {3'h0, lvl});
  endtask : wait_for

  // Reset long enough for the minimum pulse width
  task automatic do_reset(input logic ext);
    @(posedge mclk);
    resetn <= 1'b0;
    {bootDone, initDone} <= 2'h0;
    batchExtend <= ext;
    repeat (26) @(posedge mclk);
    #1;
    check("oeN", {3'h0, attnOeN}, 4'h1);
    check("state", {2'h0, seqState}, {2'h0, BISIG_RESET});
    @(posedge mclk);
    resetn <= 1'b1;
    repeat (12) @(posedge mclk);
    #1;
    check("oeN", {3'h0, attnOeN}, 4'h1);
    check("cfg", {3'h0, cfgAllowed}, 4'h0);
    @(posedge mclk);
    bootDone <= 1'b1;
    wait_for("oeN", attnOeN, 1'b0, 8);
    check("drive", {3'h0, attnLine}, 4'h1);
    check("state", {2'h0, seqState}, {2'h0, BISIG_INITIALIZING});
  endtask : do_reset

  // Normal finish, line stays low after initDone drops
  task automatic t_normal();
    do_reset(1'b0);
    @(posedge mclk);
    initDone <= 1'b1;
    wait_for("line", attnLine, 1'b0, 8);
    check("fin", {3'h0, initFinished}, 4'h1);
    @(posedge mclk);
    initDone <= 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    check("state", {2'h0, seqState}, {2'h0, BISIG_FINISHED});
    check("cfg", {3'h0, cfgAllowed}, 4'h1);
  endtask : t_normal

  // Clock enable low freezes the sequencer and its synchronisers
  task automatic t_freeze();
    do_reset(1'b0);
    @(posedge mclk);
    clkEn <= 1'b0;
    initDone <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    check("held", {2'h0, seqState}, {2'h0, BISIG_INITIALIZING});
    check("line", {3'h0, attnLine}, 4'h1);
    @(posedge mclk);
    clkEn <= 1'b1;
    wait_for("line", attnLine, 1'b0, 8);
  endtask : t_freeze

  // Deadline forces the fall; a long batch holds it off
  task automatic t_deadline(input logic ext);
    do_reset(ext);
    wait_for("over", initOverdue, 1'b1, 60);
    @(posedge mclk);
    #1;
    check("line", {3'h0, attnLine}, {3'h0, ext});
    check("fin", {3'h0, initFinished}, {3'h0, ~ext});
    @(posedge mclk);
    initDone <= 1'b1;
    wait_for("line", attnLine, 1'b0, 8);
  endtask : t_deadline

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    @(posedge mclk);
    t_normal();
    t_freeze();
    t_deadline(1'b0);
    t_deadline(1'b1);
    tally_and_finish();
  end

  // Cut a hang short
  initial begin
    repeat (2000) @(posedge mclk);
    failures++;
    tally_and_finish();
  end
endmodule : tb_boot_init_status_signal

`default_nettype wire
